// [core/rtc_trickle_burst_control.sv]
`timescale 1ns/10ps

module rtc_wr_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8
) (
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } fst_t;
  fst_t             st_reg;
  fst_t             st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready_o  = (st_reg.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (st_reg.cnt != '0);
  assign out_data_o  = mem[st_reg.rp];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wp = (st_reg.wp == AW'(DEPTH-1)) ? '0 : st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = (st_reg.rp == AW'(DEPTH-1)) ? '0 : st_reg.rp + 1'b1;
    end
    st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[st_reg.wp] <= in_data_i;
    end
  end
endmodule

// Operation
// RQ1: the charger is enabled only while the key nibble of the charger register is 1010.
// RQ2: after reset the charger register holds a disabled setting and the enable is low.
// RQ3: diode field bits 3:2 decode 01 as one diode and 10 as two diodes.
// RQ4: a diode field of 00 or 11 keeps the charger disabled whatever the key.
// RQ5: resistor field bits 1:0 decode 01 small, 10 mid and 11 large.
// RQ6: a resistor field of 00 keeps the charger disabled whatever the other fields.
// RQ7: a clock burst moves the first eight clock registers in order from address zero, lsb first.
// RQ8: with write protect set at the start of a clock burst write, none of the eight is updated.
// RQ9: the charger register is reached only by single-byte access, never by a clock burst.
// RQ10: a clock burst read copies the running time at its start and serves every byte from the copy.
// RQ11: the scratchpad holds 31 bytes of eight bits at consecutive addresses.
// RQ12: a ram burst moves the 31 bytes in order from address zero, advancing after each byte.
// RQ13: each frame opens with a command byte, lsb first: read bit, address, ram bit, enable bit.
// RQ14: an address field of all ones selects burst mode.
// RQ15: a clock burst write commits only once all eight bytes have arrived.
// RQ16: control bit 7 locks writes to all other registers; its bits 6:0 read as zero.
// RQ17: the charger enable is the and of a valid key, a one- or two-diode field and a nonzero resistor.
module rtc_trickle_burst_control (
  input  wire logic          clock_i,
  input  wire logic          rst_i,
  input  wire logic          frame_i,
  input  wire logic          sclk_i,
  input  wire logic          io_i,
  output logic               io_o,
  output logic               io_oe_n_o,
  input  wire rtc_pkg::time_t time_i,
  output logic               time_wr_o,
  output logic [6:0]         time_mask_o,
  output rtc_pkg::time_t     time_data_o,
  output logic               chg_en_o,
  output logic               two_diodes_o,
  output logic [1:0]         res_sel_o
);
  typedef struct packed {
    logic [1:0]         fsy;
    logic [1:0]         csy;
    logic               cprev;
    logic [1:0]         dsy;
    rtc_pkg::phase_t    phase;
    logic [7:0]         cmd;
    logic [7:0]         sh;
    logic [2:0]         bitcnt;
    logic [4:0]         addr;
    logic               burst;
    logic               load;
    logic [7:0]         obyte;
    logic               dout;
    logic               oe_n;
    logic               wp;
    logic               wlock;
    logic [7:0]         chg;
    rtc_pkg::chg_out_t  chg_out;
    rtc_pkg::time_t     snap;
    rtc_pkg::time_t     stage;
    logic               time_wr;
    logic [6:0]         time_mask;
    rtc_pkg::time_t     time_data;
    logic               pend;
    rtc_pkg::ram_wr_t   pend_word;
  } state_t;

  state_t           st_reg;
  state_t           st_next;
  logic [7:0]       ram [rtc_pkg::RAM_DEPTH];  // RQ11
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic             drain_ready;
  rtc_pkg::ram_wr_t fifo_out;
  logic             rise;
  logic             fall;
  logic             active;
  logic [7:0]       rx_byte;

  function automatic rtc_pkg::chg_out_t chg_decode(input logic [7:0] cfg);
    rtc_pkg::chg_out_t o;
    logic [1:0]        ds;
    ds           = cfg[rtc_pkg::DIODE_MSB:rtc_pkg::DIODE_LSB];
    o.two_diodes = (ds == rtc_pkg::DIODE_TWO);  // RQ3
    o.res_sel    = cfg[rtc_pkg::RES_MSB:rtc_pkg::RES_LSB];  // RQ5
    o.en         = (cfg[rtc_pkg::KEY_MSB:rtc_pkg::KEY_LSB] == rtc_pkg::CHG_KEY)  // RQ1
                   && (ds == rtc_pkg::DIODE_ONE || ds == rtc_pkg::DIODE_TWO)  // RQ4
                   && (o.res_sel != rtc_pkg::RES_NONE);  // RQ6 RQ17
    return o;
  endfunction

  // the serial clock is only sampled, so edges show up two cycles late; at 125 ns that is harmless
  assign rise          = st_reg.csy[1] && !st_reg.cprev;
  assign fall          = !st_reg.csy[1] && st_reg.cprev;
  assign active        = st_reg.fsy[1];
  assign rx_byte       = {st_reg.dsy[1], st_reg.sh[7:1]};
  // drain pauses behind a clock update so the ram port never competes with it
  assign drain_ready   = !st_reg.time_wr;

  rtc_wr_fifo #(
    .WIDTH (rtc_pkg::FIFO_WIDTH),
    .DEPTH (rtc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .in_valid_i  (st_reg.pend),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (st_reg.pend_word),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (drain_ready),
    .out_data_o  (fifo_out)
  );

  always_comb begin
    st_next           = st_reg;
    st_next.fsy       = {st_reg.fsy[0], frame_i};
    st_next.csy       = {st_reg.csy[0], sclk_i};
    st_next.cprev     = st_reg.csy[1];
    st_next.dsy       = {st_reg.dsy[0], io_i};
    st_next.load      = 1'b0;
    st_next.time_wr   = 1'b0;
    if (st_reg.pend && fifo_in_ready) begin
      st_next.pend = 1'b0;
    end
    if (st_reg.load) begin
      if (st_reg.cmd[rtc_pkg::CMD_RAM]) begin
        st_next.obyte = (st_reg.addr <= rtc_pkg::RAM_LAST) ? ram[st_reg.addr] : 8'h00;
      end else if (st_reg.addr < rtc_pkg::ADDR_CTRL) begin
        st_next.obyte = st_reg.burst ? st_reg.snap[st_reg.addr[2:0]]  // RQ10
                                     : time_i[st_reg.addr[2:0]];
      end else if (st_reg.addr == rtc_pkg::ADDR_CTRL) begin
        st_next.obyte = {st_reg.wp, 7'h00};  // RQ16
      end else if (st_reg.addr == rtc_pkg::ADDR_CHG) begin
        st_next.obyte = st_reg.chg;
      end else begin
        st_next.obyte = 8'h00;
      end
    end
    if (!active) begin
      st_next.phase  = rtc_pkg::PH_IDLE;
      st_next.oe_n   = 1'b1;
      st_next.bitcnt = 3'h0;
    end else begin
      unique case (st_reg.phase)
        rtc_pkg::PH_IDLE: begin
          st_next.phase = rtc_pkg::PH_CMD;
        end
        rtc_pkg::PH_CMD: begin
          if (rise) begin
            st_next.sh     = rx_byte;
            st_next.bitcnt = st_reg.bitcnt + 3'h1;
            if (st_reg.bitcnt == 3'h7) begin
              st_next.cmd   = rx_byte;  // RQ13
              st_next.burst = (rx_byte[5:1] == rtc_pkg::ADDR_BURST);  // RQ14
              st_next.addr  = st_next.burst ? 5'h00 : rx_byte[5:1];  // RQ7 RQ12
              st_next.wlock = st_reg.wp;
              if (rx_byte[rtc_pkg::CMD_RD]) begin
                st_next.phase = rtc_pkg::PH_READ;
                st_next.load  = 1'b1;
                if (st_next.burst && !rx_byte[rtc_pkg::CMD_RAM]) begin
                  st_next.snap = time_i;  // RQ10
                end
              end else begin
                st_next.phase = rtc_pkg::PH_WRITE;
              end
            end
          end
        end
        rtc_pkg::PH_READ: begin
          if (fall) begin
            st_next.dout = st_reg.obyte[st_reg.bitcnt];
            st_next.oe_n = 1'b0;
          end else if (rise) begin
            st_next.oe_n   = 1'b1;
            st_next.bitcnt = st_reg.bitcnt + 3'h1;
            if (st_reg.bitcnt == 3'h7) begin
              st_next.load = 1'b1;
              if (st_reg.burst) begin
                // clock bursts cover addresses 0..7 only, so the charger byte never appears
                if (st_reg.cmd[rtc_pkg::CMD_RAM]) begin
                  st_next.addr = (st_reg.addr == rtc_pkg::RAM_LAST) ? 5'h00
                                                                    : st_reg.addr + 5'h01;  // RQ12
                end else begin
                  st_next.addr = (st_reg.addr == rtc_pkg::ADDR_CTRL) ? 5'h00
                                                                     : st_reg.addr + 5'h01;  // RQ7 RQ9
                end
              end
            end
          end
        end
        rtc_pkg::PH_WRITE: begin
          if (rise) begin
            st_next.sh     = rx_byte;
            st_next.bitcnt = st_reg.bitcnt + 3'h1;
            if (st_reg.bitcnt == 3'h7) begin
              st_next.phase = rtc_pkg::PH_DONE;
              if (!st_reg.cmd[rtc_pkg::CMD_EN]) begin
                st_next.phase = rtc_pkg::PH_DONE;
              end else if (st_reg.cmd[rtc_pkg::CMD_RAM]) begin
                if (!st_reg.wp && st_reg.addr <= rtc_pkg::RAM_LAST) begin  // RQ16
                  st_next.pend      = 1'b1;
                  st_next.pend_word = '{addr: st_reg.addr, data: rx_byte};
                end
                if (st_reg.burst && st_reg.addr != rtc_pkg::RAM_LAST) begin
                  st_next.addr  = st_reg.addr + 5'h01;  // RQ12
                  st_next.phase = rtc_pkg::PH_WRITE;
                end
              end else if (st_reg.burst) begin
                // the control byte has no staging slot, so only bytes 0..6 are staged
                if (st_reg.addr < rtc_pkg::ADDR_CTRL) begin
                  st_next.stage[st_reg.addr[2:0]] = rx_byte;  // RQ7
                  st_next.addr                    = st_reg.addr + 5'h01;
                  st_next.phase                   = rtc_pkg::PH_WRITE;
                end else if (!st_reg.wlock) begin  // RQ8
                  st_next.time_wr   = 1'b1;  // RQ15
                  st_next.time_mask = rtc_pkg::MASK_ALL;
                  st_next.time_data = st_reg.stage;
                  st_next.wp        = rx_byte[rtc_pkg::WP_BIT];
                end
              end else if (st_reg.addr == rtc_pkg::ADDR_CTRL) begin
                st_next.wp = rx_byte[rtc_pkg::WP_BIT];  // RQ16
              end else if (!st_reg.wp) begin  // RQ16
                if (st_reg.addr < rtc_pkg::ADDR_CTRL) begin
                  st_next.time_wr                        = 1'b1;
                  st_next.time_mask                      = 7'(8'h01 << st_reg.addr[2:0]);
                  st_next.time_data                      = time_i;
                  st_next.time_data[st_reg.addr[2:0]]    = rx_byte;
                end else if (st_reg.addr == rtc_pkg::ADDR_CHG) begin
                  st_next.chg = rx_byte;  // RQ9
                end
              end
            end
          end
        end
        rtc_pkg::PH_DONE: begin
          st_next.phase = rtc_pkg::PH_DONE;
        end
        default: begin
          st_next.phase = rtc_pkg::PH_IDLE;
        end
      endcase
    end
    st_next.chg_out = chg_decode(st_next.chg);  // RQ17
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg       <= '0;
      st_reg.oe_n  <= 1'b1;
      st_reg.chg   <= rtc_pkg::CHG_RESET;  // RQ2
      st_reg.phase <= rtc_pkg::PH_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge clock_i) begin
    if (fifo_out_valid && drain_ready) begin
      ram[fifo_out.addr] <= fifo_out.data;  // RQ11 RQ12
    end
  end

  assign io_o         = st_reg.dout;
  assign io_oe_n_o    = st_reg.oe_n;
  assign time_wr_o    = st_reg.time_wr;
  assign time_mask_o  = st_reg.time_mask;
  assign time_data_o  = st_reg.time_data;
  assign chg_en_o     = st_reg.chg_out.en;
  assign two_diodes_o = st_reg.chg_out.two_diodes;
  assign res_sel_o    = st_reg.chg_out.res_sel;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  AST_KEY: assert property (chg_en_o |-> st_reg.chg[7:4] == 4'ha)  // RQ1
    else $error("charger enabled without key");
  AST_RESET_OFF: assert property ($past(rst_i) |-> !chg_en_o && st_reg.chg == 8'h00)  // RQ2
    else $error("charger not disabled after reset");
  AST_DIODE: assert property (two_diodes_o == (st_reg.chg[3:2] == 2'h2))  // RQ3
    else $error("diode decode wrong");
  AST_DIODE_OFF: assert property (st_reg.chg[3:2] inside {2'h0, 2'h3} |-> !chg_en_o)  // RQ4
    else $error("charger on with bad diode field");
  AST_RES_OFF: assert property (res_sel_o == 2'h0 |-> !chg_en_o)  // RQ6
    else $error("charger on without resistor");
  AST_AND: assert property (chg_en_o == (st_reg.chg[7:4] == 4'ha && st_reg.chg[1:0] != 2'h0  // RQ17
                                         && st_reg.chg[3:2] inside {2'h1, 2'h2}))
    else $error("charger enable not the and of its fields");
  AST_BURST_START: assert property ($rose(st_reg.phase == rtc_pkg::PH_READ) && st_reg.burst
                                    |-> st_reg.addr == 5'h00)  // RQ7
    else $error("burst does not start at zero");
  AST_WP_BURST: assert property (time_wr_o && time_mask_o == 7'h7f |-> !st_reg.wlock)  // RQ8
    else $error("clock burst written while protected");
  AST_SNAP: assert property (st_reg.phase == rtc_pkg::PH_READ && $past(st_reg.phase)
                             == rtc_pkg::PH_READ |-> $stable(st_reg.snap))  // RQ10
    else $error("snapshot changed during read");
  AST_RAM_ADDR: assert property (st_reg.burst && st_reg.cmd[6] && st_reg.phase
                                 != rtc_pkg::PH_IDLE |-> st_reg.addr <= 5'h1e)  // RQ12
    else $error("ram burst address out of range");
  AST_CTRL_ZERO: assert property (st_reg.load && !st_reg.cmd[6] && st_reg.addr == 5'h07
                                  |=> st_reg.obyte[6:0] == 7'h00)  // RQ16
    else $error("control low bits not zero");
  AST_OE_READ: assert property (!io_oe_n_o |-> st_reg.phase == rtc_pkg::PH_READ)  // RQ13
    else $error("pin driven outside a read");

  COV_CLK_BURST_RD: cover property (st_reg.load && st_reg.burst && !st_reg.cmd[6]);
  COV_CLK_BURST_WR: cover property (time_wr_o && time_mask_o == 7'h7f);
  COV_RAM_BURST_WR: cover property (st_reg.pend && st_reg.burst && st_reg.addr == 5'h1e);
  COV_CHG_ON: cover property ($rose(chg_en_o));
endmodule

// [core/rtc_pkg.sv]
package rtc_pkg;
  localparam logic [3:0] CHG_KEY       = 4'ha;
  localparam int         KEY_MSB       = 7;
  localparam int         KEY_LSB       = 4;
  localparam int         DIODE_MSB     = 3;
  localparam int         DIODE_LSB     = 2;
  localparam int         RES_MSB       = 1;
  localparam int         RES_LSB       = 0;
  localparam logic [1:0] DIODE_ONE     = 2'h1;
  localparam logic [1:0] DIODE_TWO     = 2'h2;
  localparam logic [1:0] RES_NONE      = 2'h0;
  localparam logic [7:0] CHG_RESET     = 8'h00;
  localparam logic [4:0] ADDR_BURST    = 5'h1f;
  localparam logic [4:0] ADDR_CTRL     = 5'h07;
  localparam logic [4:0] ADDR_CHG      = 5'h08;
  localparam logic [4:0] RAM_LAST      = 5'h1e;
  localparam int         RAM_DEPTH     = 31;
  localparam int         TIME_BYTES    = 7;
  localparam logic [6:0] MASK_ALL      = 7'h7f;
  localparam int         CMD_RD        = 0;
  localparam int         CMD_RAM       = 6;
  localparam int         CMD_EN        = 7;
  localparam int         WP_BIT        = 7;
  localparam int         FIFO_DEPTH    = 8;
  localparam int         FIFO_WIDTH    = 13;
  localparam int         CLK_PERIOD_NS = 5;

  typedef logic [TIME_BYTES-1:0][7:0] time_t;
  typedef enum logic [2:0] {PH_IDLE, PH_CMD, PH_WRITE, PH_READ, PH_DONE} phase_t;
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] data;
  } ram_wr_t;
  typedef struct packed {
    logic       en;
    logic       two_diodes;
    logic [1:0] res_sel;
  } chg_out_t;
endpackage

// [test/host_model.sv]
`timescale 1ns/10ps
module host_model (
  input  wire logic clock_i,
  input  wire logic io_i,
  output logic      frame_o,
  output logic      sclk_o,
  output logic      oe_n_o,
  output logic      bit_o
);
  // low half can be stretched to play a slow host
  int low_cycles = 12;
  initial begin
    frame_o = 1'b0;
    sclk_o  = 1'b0;
    oe_n_o  = 1'b1;
    bit_o   = 1'b0;
  end
  // fall, low half, rise, high half; read bits are taken just before the rise
  task automatic cyc(input logic drv, input logic b, output logic seen);
    @(posedge clock_i);
    sclk_o <= 1'b0;
    oe_n_o <= !drv;
    bit_o  <= b;
    repeat (low_cycles) @(posedge clock_i);
    seen = io_i;
    sclk_o <= 1'b1;
    // 12 low plus 13 high cycles make the 125 ns link period
    repeat (12) @(posedge clock_i);
  endtask
  // serial clock is already low when the frame opens
  task automatic open_f();
    @(posedge clock_i);
    frame_o <= 1'b1;
    repeat (8) @(posedge clock_i);
  endtask
  task automatic close_f();
    @(posedge clock_i);
    sclk_o <= 1'b0;
    repeat (low_cycles) @(posedge clock_i);
    frame_o <= 1'b0;
    oe_n_o  <= 1'b1;
    repeat (20) @(posedge clock_i);
  endtask
  task automatic send(input logic [7:0] b);
    logic s;
    for (int i = 0; i < 8; i++) cyc(1'b1, b[i], s);
  endtask
  task automatic recv(output logic [7:0] b);
    for (int i = 0; i < 8; i++) cyc(1'b0, 1'b0, b[i]);
  endtask
endmodule

// [test/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  logic           clock_i = 1'b0;
  logic           rst_i = 1'b1;
  logic           frame, sclk, h_oe_n, h_bit, io_o, io_oe_n_o;
  logic           time_wr_o, chg_en_o, two_diodes_o;
  logic [1:0]     res_sel_o;
  logic [6:0]     time_mask_o, wr_mask;
  rtc_pkg::time_t time_i = '0;
  rtc_pkg::time_t time_data_o, wr_data;
  int             miscompares = 0;
  int             cmp_count = 0;
  int             wr_count = 0;
  int             cycles = 0;
  wire            io_line;

  // a released data line falls to its pull-down level
  assign io_line = !io_oe_n_o ? io_o : (!h_oe_n ? h_bit : 1'b0);

  rtc_trickle_burst_control rtc_trickle_burst_control_i (
    .clock_i(clock_i), .rst_i(rst_i), .frame_i(frame), .sclk_i(sclk),
    .io_i(io_line), .io_o(io_o), .io_oe_n_o(io_oe_n_o), .time_i(time_i),
    .time_wr_o(time_wr_o), .time_mask_o(time_mask_o), .time_data_o(time_data_o),
    .chg_en_o(chg_en_o), .two_diodes_o(two_diodes_o), .res_sel_o(res_sel_o));
  host_model host_model_i (
    .clock_i(clock_i), .io_i(io_line), .frame_o(frame), .sclk_o(sclk),
    .oe_n_o(h_oe_n), .bit_o(h_bit));

  always #2.5 clock_i = ~clock_i;

  // the write pulse stands one cycle, so it is caught on every edge
  always @(posedge clock_i) begin
    cycles++;
    if (time_wr_o === 1'b1) begin
      wr_count++;
      wr_mask = time_mask_o;
      wr_data = time_data_o;
    end
    if (cycles == 80000) begin
      miscompares++;
      $display("ERROR timeout expected done seen hang");
      results();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr1(input logic [7:0] cmd, input logic [7:0] d);
    host_model_i.open_f();
    host_model_i.send(cmd);
    host_model_i.send(d);
    host_model_i.close_f();
  endtask
  task automatic rd1(input logic [7:0] cmd, output logic [7:0] d);
    host_model_i.open_f();
    host_model_i.send(cmd);
    host_model_i.recv(d);
    host_model_i.close_f();
  endtask

  task automatic t_reset();
    logic [7:0] d;
    chk("chg_out", 8'h00, {4'h0, chg_en_o, two_diodes_o, res_sel_o});
    chk("io_oe_n", 8'h01, {7'h0, io_oe_n_o});
    rd1(8'h91, d);
    chk("chg_rd", 8'h00, d);
  endtask
  task automatic t_charger();
    logic [7:0] v, d;
    logic       en;
    for (int k = 0; k < 32; k++) begin
      v = {k[4] ? 4'h5 : 4'ha, k[3:0]};
      en = !k[4] && (k[3:2] == 2'h1 || k[3:2] == 2'h2) && k[1:0] != 2'h0;
      wr1(8'h90, v);
      chk("chg_en", {7'h0, en}, {7'h0, chg_en_o});
      if (en) chk("sel", {5'h0, k[3:2] == 2'h2, k[1:0]}, {5'h0, two_diodes_o, res_sel_o});
    end
    rd1(8'h91, d);
    chk("chg_rd", v, d);
  endtask
  task automatic t_bwrite();
    int n;
    n = wr_count;
    host_model_i.open_f();
    host_model_i.send(8'hbe);
    for (int i = 0; i < 7; i++) host_model_i.send(8'h10 + 8'(i));
    chk("early", 8'h00, 8'(wr_count - n));
    host_model_i.send(8'h00);
    host_model_i.close_f();
    chk("pulses", 8'h01, 8'(wr_count - n));
    chk("mask", 8'h7f, {1'b0, wr_mask});
    for (int i = 0; i < 7; i++) chk("wbyte", 8'h10 + 8'(i), wr_data[i]);
    n = wr_count;
    wr1(8'h84, 8'h5a);
    chk("s_pulses", 8'h01, 8'(wr_count - n));
    chk("s_mask", 8'h04, {1'b0, wr_mask});
    chk("s_byte", 8'h5a, wr_data[2]);
    chk("s_keep", 8'h00, wr_data[0]);
  endtask
  task automatic t_bread();
    logic [7:0]     d;
    rtc_pkg::time_t t1;
    for (int i = 0; i < 7; i++) t1[i] = 8'h21 + 8'(i);
    time_i <= t1;
    host_model_i.open_f();
    host_model_i.send(8'hbf);
    // time moves on while the burst is read out
    time_i <= ~t1;
    for (int i = 0; i < 9; i++) begin
      host_model_i.recv(d);
      chk("rbyte", (i == 7) ? 8'h00 : t1[i % 8], d);
    end
    host_model_i.close_f();
    // a single read serves the running time, not the burst copy
    rd1(8'h87, d);
    chk("rd_single", ~t1[3], d);
  endtask
  task automatic t_protect();
    logic [7:0] d;
    int         n;
    wr1(8'h90, 8'ha5);
    wr1(8'h8e, 8'hff);
    rd1(8'h8f, d);
    chk("ctrl_rd", 8'h80, d);
    wr1(8'h90, 8'h00);
    chk("chg_lock", 8'h01, {7'h0, chg_en_o});
    n = wr_count;
    host_model_i.open_f();
    host_model_i.send(8'hbe);
    for (int i = 0; i < 8; i++) host_model_i.send(8'h00);
    host_model_i.close_f();
    chk("lock_burst", 8'h00, 8'(wr_count - n));
    wr1(8'h8e, 8'h00);
    rd1(8'h8f, d);
    chk("ctrl_clr", 8'h00, d);
    wr1(8'h10, 8'h00);
    rd1(8'h91, d);
    chk("no_enable", 8'ha5, d);
  endtask
  task automatic t_ram();
    logic [7:0] d;
    host_model_i.open_f();
    host_model_i.send(8'hfe);
    for (int i = 0; i < 31; i++) host_model_i.send(8'hc3 ^ 8'(i));
    host_model_i.close_f();
    rd1(8'hfd, d);
    chk("ram30", 8'hdd, d);
    wr1(8'hca, 8'h77);
    host_model_i.open_f();
    host_model_i.send(8'hff);
    for (int i = 0; i < 32; i++) begin
      host_model_i.recv(d);
      chk("ram_rd", (i == 5) ? 8'h77 : 8'hc3 ^ 8'(i % 31), d);
    end
    host_model_i.close_f();
  endtask
  task automatic t_fifo();
    logic [7:0] d;
    logic       s;
    host_model_i.open_f();
    host_model_i.send(8'hfe);
    for (int i = 0; i < 8; i++) host_model_i.send(8'h50 + 8'(i));
    // a cut byte at the end of the frame must never reach the ram
    for (int i = 0; i < 3; i++) host_model_i.cyc(1'b1, 1'b1, s);
    host_model_i.close_f();
    chk("fifo_empty", 8'h00, {7'h0, rtc_trickle_burst_control_i.fifo_out_valid});
    for (int i = 0; i < 8; i++) begin
      rd1({2'b11, 5'(i), 1'b1}, d);
      chk("ram_q", 8'h50 + 8'(i), d);
    end
    rd1(8'hd1, d);
    chk("ram_cut", 8'hcb, d);
    rd1(8'hfd, d);
    chk("ram_keep", 8'hdd, d);
  endtask

  task automatic results();
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    t_reset();
    t_charger();
    t_bwrite();
    t_bread();
    t_protect();
    t_ram();
    t_fifo();
    results();
  end
endmodule
